// >>> core/lpsd_consts.vh
// Command codes, field positions and reset values for the SDRAM read/activate block
`ifndef LPSD_CONSTS_VH
`define LPSD_CONSTS_VH
// Command code is {ras_n, cas_n, we_n} with chip select low
`define LPSD_CMD_LMR   3'h0
`define LPSD_CMD_PRE   3'h2
`define LPSD_CMD_ACT   3'h3
`define LPSD_CMD_WRITE 3'h4
`define LPSD_CMD_READ  3'h5
`define LPSD_CMD_BST   3'h6
// Bank selects of a load-mode command
`define LPSD_BA_MODE   2'h0
`define LPSD_BA_EXT    2'h2
// Field positions in the address bus
`define LPSD_BL_HI     2
`define LPSD_BL_LO     0
`define LPSD_CL_HI     6
`define LPSD_CL_LO     4
`define LPSD_PARTIAL_ARRAY_REFRESH_HI   2
`define LPSD_PARTIAL_ARRAY_REFRESH_LO   0
`define LPSD_DS_HI     6
`define LPSD_DS_LO     5
`define LPSD_AP_BIT    10
// Burst length codes and the latency 3 code
`define LPSD_BL_1      3'h0
`define LPSD_BL_2      3'h1
`define LPSD_BL_4      3'h2
`define LPSD_BL_8      3'h3
`define LPSD_BL_PAGE   3'h7
`define LPSD_CL_3      3'h3
// Partial refresh codes
`define LPSD_PARTIAL_ARRAY_REFRESH_FULL 3'h0
`define LPSD_PARTIAL_ARRAY_REFRESH_HALF 3'h1
`define LPSD_PARTIAL_ARRAY_REFRESH_QTR  3'h2
`define LPSD_PARTIAL_ARRAY_REFRESH_8TH  3'h5
`define LPSD_PARTIAL_ARRAY_REFRESH_16TH 3'h6
// Drive strength codes
`define LPSD_DS_FULL   2'h0
`define LPSD_DS_HALF   2'h1
`define LPSD_DS_QTR    2'h2
`define LPSD_DS_3QTR   2'h3
`define LPSD_OHM_FULL  7'h19
`define LPSD_OHM_3QTR  7'h25
`define LPSD_OHM_HALF  7'h37
`define LPSD_OHM_QTR   7'h50
// Reset values
`define LPSD_BL_RST    3'h0
`define LPSD_CL_RST    3'h2
`define LPSD_PARTIAL_ARRAY_REFRESH_RST  3'h0
`define LPSD_DS_RST    2'h0
`endif

// >>> core/lpsd_read_act.v
// Low-power SDRAM core: extended mode store, bank activation and read bursts
`timescale 1ns/10ps
`include "lpsd_consts.vh"

module lpsd_read_act #(
  parameter ROW_W = 12,
  parameter COL_W = 9,
  parameter DQ_W  = 16
) (
  input  wire             clk_sys,
  input  wire             reset,
  input  wire             clk_en,
  input  wire             cs_n,
  input  wire             ras_n,
  input  wire             cas_n,
  input  wire             we_n,
  input  wire [1:0]       bank_select,
  input  wire [ROW_W-1:0] addr,
  input  wire             dqm,
  input  wire [DQ_W-1:0]  dq_in,
  output reg  [DQ_W-1:0]  dq_out,
  output reg              dq_oe,
  output reg  [3:0]       bank_open,
  output reg              read_busy,
  output reg              invalid_write,
  output reg  [3:0]       partial_array_refresh_bank_mask,
  output reg  [1:0]       partial_array_refresh_row_msb_zero,
  output reg  [1:0]       drive_strength,
  output reg  [6:0]       drive_ohms
);

  localparam AW = 2 + ROW_W + COL_W;

  ////////////////////////////////////////////////////////////////////////////
  // Storage and configuration
  reg [DQ_W-1:0]  mem [0:(1<<AW)-1];
  reg [ROW_W-1:0] row_of [0:3];
  reg [2:0]       burst_length;
  reg [2:0]       read_latency;
  reg [2:0]       partial_array_refresh;

  // Burst engine: rd_col holds the column of the next element to issue
  reg [1:0]       rd_bank;
  reg [COL_W-1:0] rd_col;
  reg [3:0]       rd_left;
  reg             rd_page;
  reg             rd_ap;
  reg             st1_v;
  reg             st2_v;
  reg [DQ_W-1:0]  st1_d;
  reg [DQ_W-1:0]  st2_d;
  reg             dm1;

  ////////////////////////////////////////////////////////////////////////////
  // Command decode
  wire [2:0] cmd      = {ras_n, cas_n, we_n};
  wire       is_act   = !cs_n && cmd == `LPSD_CMD_ACT;
  wire       is_read  = !cs_n && cmd == `LPSD_CMD_READ;
  wire       is_write = !cs_n && cmd == `LPSD_CMD_WRITE;
  wire       is_pre   = !cs_n && cmd == `LPSD_CMD_PRE;
  wire       is_bst   = !cs_n && cmd == `LPSD_CMD_BST;
  wire       is_lmr   = !cs_n && cmd == `LPSD_CMD_LMR;
  wire       pre_all  = addr[`LPSD_AP_BIT];
  wire       pre_hit  = is_pre && (pre_all || bank_select == rd_bank);

  reg [COL_W-1:0] wrap_mask;
  reg [3:0]       blen_m1;
  always @* begin
    case (burst_length)
      `LPSD_BL_1: begin
        wrap_mask = {COL_W{1'b0}};
        blen_m1   = 4'h0;
      end
      `LPSD_BL_2: begin
        wrap_mask = {{(COL_W-1){1'b0}}, 1'b1};
        blen_m1   = 4'h1;
      end
      `LPSD_BL_4: begin
        wrap_mask = {{(COL_W-2){1'b0}}, 2'h3};
        blen_m1   = 4'h3;
      end
      `LPSD_BL_8: begin
        wrap_mask = {{(COL_W-3){1'b0}}, 3'h7};
        blen_m1   = 4'h7;
      end
      default: begin
        wrap_mask = {COL_W{1'b1}};
        blen_m1   = 4'h0;
      end
    endcase
  end
  wire page_mode = burst_length == `LPSD_BL_PAGE;

  ////////////////////////////////////////////////////////////////////////////
  // Element issue: a new read takes over the column stream at once
  wire             stop_rd   = is_write || is_bst || pre_hit;
  wire             issue_v   = is_read || (read_busy && !stop_rd);
  wire [1:0]       issue_bk  = is_read ? bank_select : rd_bank;
  wire [COL_W-1:0] issue_col = is_read ? addr[COL_W-1:0] : rd_col;
  wire [COL_W-1:0] col_inc   = issue_col + {{(COL_W-1){1'b0}}, 1'b1};
  // Wraps within the burst block; page mode wraps to column 0
  wire [COL_W-1:0] next_col  = (issue_col & ~wrap_mask) | (col_inc & wrap_mask);
  wire [AW-1:0]    issue_adr = {issue_bk, row_of[issue_bk], issue_col};
  wire [DQ_W-1:0]  issue_d   = mem[issue_adr];
  wire             cl3       = read_latency == `LPSD_CL_3;
  wire             out_v     = cl3 ? st2_v : st1_v;
  wire [DQ_W-1:0]  out_d     = cl3 ? st2_d : st1_d;
  wire             rd_flight = read_busy || st1_v || st2_v || dq_oe;
  // A write that cuts a read is honoured only when the mask led it by a clock
  wire             write_ok  = !rd_flight || dm1;
  wire             rd_last   = !is_read && read_busy && !stop_rd
                               && !rd_page && rd_left == 4'h1;
  wire [AW-1:0]    wr_adr    = {bank_select, row_of[bank_select], addr[COL_W-1:0]};

  ////////////////////////////////////////////////////////////////////////////
  // Memory write: the single element that arrives with the command
  always @(posedge clk_sys) begin
    if (clk_en && !reset && is_write && write_ok && !dqm && bank_open[bank_select]) begin
      mem[wr_adr] <= dq_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control state
  always @(posedge clk_sys) begin
    if (reset) begin
      burst_length          <= `LPSD_BL_RST;
      read_latency          <= `LPSD_CL_RST;
      partial_array_refresh <= `LPSD_PARTIAL_ARRAY_REFRESH_RST;
      drive_strength        <= `LPSD_DS_RST;
      bank_open             <= 4'h0;
      read_busy             <= 1'b0;
      rd_bank               <= 2'h0;
      rd_col                <= {COL_W{1'b0}};
      rd_left               <= 4'h0;
      rd_page               <= 1'b0;
      rd_ap                 <= 1'b0;
      st1_v                 <= 1'b0;
      st2_v                 <= 1'b0;
      st1_d                 <= {DQ_W{1'b0}};
      st2_d                 <= {DQ_W{1'b0}};
      dm1                   <= 1'b0;
      dq_out                <= {DQ_W{1'b0}};
      dq_oe                 <= 1'b0;
      invalid_write         <= 1'b0;
    end else if (clk_en) begin
      if (is_lmr && bank_select == `LPSD_BA_MODE) begin
        burst_length <= addr[`LPSD_BL_HI:`LPSD_BL_LO];
        read_latency <= addr[`LPSD_CL_HI:`LPSD_CL_LO];
      end
      // Temperature bits are not stored; only reset or an extended load changes these
      if (is_lmr && bank_select == `LPSD_BA_EXT) begin
        partial_array_refresh <= addr[`LPSD_PARTIAL_ARRAY_REFRESH_HI:`LPSD_PARTIAL_ARRAY_REFRESH_LO];
        drive_strength        <= addr[`LPSD_DS_HI:`LPSD_DS_LO];
      end
      if (is_act) begin
        bank_open[bank_select] <= 1'b1;
      end
      if (is_pre) begin
        if (pre_all) begin
          bank_open <= 4'h0;
        end else begin
          bank_open[bank_select] <= 1'b0;
        end
      end
      if (is_read) begin
        rd_bank   <= bank_select;
        rd_col    <= next_col;
        rd_left   <= blen_m1;
        rd_page   <= page_mode;
        rd_ap     <= addr[`LPSD_AP_BIT] && !page_mode;
        read_busy <= page_mode || blen_m1 != 4'h0;
        if (addr[`LPSD_AP_BIT] && !page_mode && blen_m1 == 4'h0) begin
          bank_open[bank_select] <= 1'b0;
        end
      end else if (stop_rd) begin
        read_busy <= 1'b0;
      end else if (read_busy) begin
        rd_col  <= next_col;
        rd_left <= rd_left - 4'h1;
        if (rd_last) begin
          read_busy <= 1'b0;
          if (rd_ap) begin
            bank_open[rd_bank] <= 1'b0;
          end
        end
      end
      // Stage count sets the latency; a write flushes what is in flight
      st1_v  <= issue_v && !is_write;
      st1_d  <= issue_d;
      st2_v  <= st1_v && !is_write;
      st2_d  <= st1_d;
      dm1    <= dqm;
      // Driven from edge n+m-1 so data is settled by edge n+m
      dq_oe  <= out_v && !dm1 && !is_write;
      dq_out <= out_d;
      invalid_write <= is_write && !write_ok;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Open rows kept apart from reset; a bank's row is unknown until its first activate
  always @(posedge clk_sys) begin
    if (clk_en && is_act) begin
      row_of[bank_select] <= addr;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Self refresh coverage and driver impedance for the pad and refresh logic
  always @(posedge clk_sys) begin
    if (reset) begin
      partial_array_refresh_bank_mask    <= 4'hF;
      partial_array_refresh_row_msb_zero <= 2'h0;
      drive_ohms        <= `LPSD_OHM_FULL;
    end else if (clk_en) begin
      case (partial_array_refresh)
        `LPSD_PARTIAL_ARRAY_REFRESH_HALF: begin
          partial_array_refresh_bank_mask    <= 4'h3;
          partial_array_refresh_row_msb_zero <= 2'h0;
        end
        `LPSD_PARTIAL_ARRAY_REFRESH_QTR: begin
          partial_array_refresh_bank_mask    <= 4'h1;
          partial_array_refresh_row_msb_zero <= 2'h0;
        end
        `LPSD_PARTIAL_ARRAY_REFRESH_8TH: begin
          partial_array_refresh_bank_mask    <= 4'h1;
          partial_array_refresh_row_msb_zero <= 2'h1;
        end
        `LPSD_PARTIAL_ARRAY_REFRESH_16TH: begin
          partial_array_refresh_bank_mask    <= 4'h1;
          partial_array_refresh_row_msb_zero <= 2'h3;
        end
        default: begin
          partial_array_refresh_bank_mask    <= 4'hF;
          partial_array_refresh_row_msb_zero <= 2'h0;
        end
      endcase
      case (drive_strength)
        `LPSD_DS_HALF: drive_ohms <= `LPSD_OHM_HALF;
        `LPSD_DS_QTR:  drive_ohms <= `LPSD_OHM_QTR;
        `LPSD_DS_3QTR: drive_ohms <= `LPSD_OHM_3QTR;
        default:       drive_ohms <= `LPSD_OHM_FULL;
      endcase
    end
  end

endmodule

// >>> dv/lpsd_read_act_props.sv
// Assertions and covers on the ports of the SDRAM read/activate block
`timescale 1ns/10ps
module lpsd_read_act_props #(
  parameter ROW_W = 12,
  parameter COL_W = 9,
  parameter DQ_W  = 16
) (
  input wire             clk_sys,
  input wire             reset,
  input wire             clk_en,
  input wire             cs_n,
  input wire             ras_n,
  input wire             cas_n,
  input wire             we_n,
  input wire [1:0]       bank_select,
  input wire [ROW_W-1:0] addr,
  input wire             dqm,
  input wire             dq_oe,
  input wire [3:0]       bank_open,
  input wire             invalid_write,
  input wire [3:0]       partial_array_refresh_bank_mask,
  input wire [6:0]       drive_ohms
);
  wire [2:0] cmd = {ras_n, cas_n, we_n};
  // A command counts only on an edge where the clock enable lets the block run
  wire       sel = clk_en && !cs_n;
  wire       rd  = sel && cmd == 3'h5;
  wire       wr  = sel && cmd == 3'h4;
  wire       ext = sel && cmd == 3'h0 && bank_select == 2'h2;
  reg        cl3;
  // Latency is not a port, so it is tracked from the base mode loads
  always @(posedge clk_sys)
    if (reset) cl3 <= 1'b0;
    else if (sel && cmd == 3'h0 && bank_select == 2'h0) cl3 <= addr[6:4] == 3'h3;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  // The decoded outputs trail the stored field by one more edge
  a_ext_partial_array_refresh_qtr: assert property (ext && addr[2:0] == 3'h2 |-> ##2 partial_array_refresh_bank_mask == 4'h1)
    else $error("quarter refresh mask wrong");
  a_ext_drive_half: assert property (ext && addr[6:5] == 2'h1 |-> ##2 drive_ohms == 7'h37)
    else $error("half drive impedance wrong");
  a_ext_keeps: assert property (!ext |-> ##2 $stable(drive_ohms) && $stable(partial_array_refresh_bank_mask))
    else $error("extended settings changed without a load");
  a_read_cl2: assert property (rd && !cl3 && !dqm ##1 !wr |=> dq_oe)
    else $error("latency two read not driven");
  a_read_cl3: assert property (rd && cl3 ##1 !wr && !dqm ##1 !wr |=> dq_oe)
    else $error("latency three read not driven");
  a_write_floats: assert property (wr |=> !dq_oe)
    else $error("data driven after a write");
  a_invalid_cause: assert property (invalid_write |-> $past(wr) || $past(wr, 2))
    else $error("invalid write flag without a write");
  a_invalid_pulse: assert property (invalid_write |=> !invalid_write)
    else $error("invalid write flag longer than one cycle");
  a_act_opens: assert property (sel && cmd == 3'h3 |=> bank_open[$past(bank_select)])
    else $error("activated bank not open");
  a_pre_all: assert property (sel && cmd == 3'h2 && addr[10] |=> bank_open == 4'h0)
    else $error("banks open after precharge all");
  c_cl3_read: cover property (rd && cl3);
  c_bad_write: cover property (invalid_write);
  c_ext_load: cover property (ext);
endmodule
bind lpsd_read_act lpsd_read_act_props #(.ROW_W(ROW_W), .COL_W(COL_W), .DQ_W(DQ_W)) props_u (
  .clk_sys(clk_sys), .reset(reset), .clk_en(clk_en), .cs_n(cs_n), .ras_n(ras_n),
  .cas_n(cas_n), .we_n(we_n),
  .bank_select(bank_select), .addr(addr), .dqm(dqm), .dq_oe(dq_oe), .bank_open(bank_open),
  .invalid_write(invalid_write), .partial_array_refresh_bank_mask(partial_array_refresh_bank_mask), .drive_ohms(drive_ohms));

// >>> dv/lpsd_ctrl_model.sv
// Memory controller stand-in: command, address, mask and write data pins
`timescale 1ns/10ps
module lpsd_ctrl_model (
  input  wire        clk_sys,
  output reg         cs_n,
  output reg         ras_n,
  output reg         cas_n,
  output reg         we_n,
  output reg  [1:0]  bank_select,
  output reg  [10:0] addr,
  output reg         dqm,
  output reg  [15:0] dq_in
);
  initial begin
    {cs_n, ras_n, cas_n, we_n, bank_select, addr, dqm, dq_in} = {4'hF, 30'h00000000};
  end
  // One command per falling edge; the caller orders them and leaves the required gaps
  task cmd(input [2:0] c, input [1:0] b, input [10:0] a, input m, input [15:0] d);
    begin
      @(negedge clk_sys);
      {cs_n, ras_n, cas_n, we_n} <= {1'b0, c};
      bank_select <= b;
      addr <= (c == 3'h0) ? {4'h0, a[6:0]} : a;
      dqm <= m;
      // Undriven data lines churn so a stale value never passes for data
      dq_in <= (c == 3'h4) ? d : ~dq_in;
    end
  endtask
endmodule

// >>> dv/lpsd_read_act_tb_top.sv
// Self-checking bench for the SDRAM read/activate block
`timescale 1ns/10ps
module lpsd_read_act_tb_top;
  reg         clk_sys = 1'b0;
  reg         reset = 1'b1;
  reg         flag;
  reg         clk_en = 1'b1;
  reg  [31:0] seed = 32'h0000001A;
  reg  [15:0] exp_mem [0:63];
  wire        cs_n, ras_n, cas_n, we_n, dqm, dq_oe, read_busy, invalid_write;
  wire [1:0]  bank_select, drive_strength, partial_array_refresh_row_msb_zero;
  wire [10:0] addr;
  wire [15:0] dq_in, dq_out;
  wire [3:0]  bank_open, partial_array_refresh_bank_mask;
  wire [6:0]  drive_ohms;
  integer     fail_count = 0, total_checks = 0, i, j;
  always #12.5 clk_sys = ~clk_sys;
  lpsd_read_act #(.ROW_W(11), .COL_W(4), .DQ_W(16)) dut_u (
    .clk_sys(clk_sys), .reset(reset), .clk_en(clk_en), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n),
    .we_n(we_n), .bank_select(bank_select), .addr(addr), .dqm(dqm), .dq_in(dq_in),
    .dq_out(dq_out), .dq_oe(dq_oe), .bank_open(bank_open), .read_busy(read_busy),
    .invalid_write(invalid_write), .partial_array_refresh_bank_mask(partial_array_refresh_bank_mask),
    .partial_array_refresh_row_msb_zero(partial_array_refresh_row_msb_zero), .drive_strength(drive_strength),
    .drive_ohms(drive_ohms));
  lpsd_ctrl_model ctl_u (.clk_sys(clk_sys), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n),
    .we_n(we_n), .bank_select(bank_select), .addr(addr), .dqm(dqm), .dq_in(dq_in));
  function [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    rnd = seed;
  endfunction
  function [3:0] exp_mask(input [2:0] c);
    exp_mask = c == 3'h1 ? 4'h3 : (c == 3'h2 || c == 3'h5 || c == 3'h6) ? 4'h1 : 4'hF;
  endfunction
  function [6:0] exp_ohm(input [1:0] d);
    exp_ohm = d == 2'h0 ? 7'h19 : d == 2'h1 ? 7'h37 : d == 2'h2 ? 7'h50 : 7'h25;
  endfunction
  task check(input [15:0] seen, input [15:0] want);
    begin
      total_checks = total_checks + 1;
      if (seen !== want) begin
        fail_count = fail_count + 1;
        $display("MISMATCH at %0t: seen %h expected %h", $time, seen, want);
      end
    end
  endtask
  task close_out;
    begin
      $display("checks %0d, mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask
  task nop(input m);
    ctl_u.cmd(3'h7, 2'h0, 11'h000, m, 16'h0000);
  endtask
  // Read, then the stop command after len elements; every element and the tail are checked
  task rd_chk(input [1:0] b, input [3:0] col, input integer cl, bl, len, input [2:0] stop);
    integer   k;
    reg [3:0] c;
    begin
      ctl_u.cmd(3'h5, b, {7'h00, col}, 1'b0, 16'h0000);
      for (k = 1; k < cl + len; k = k + 1) begin
        ctl_u.cmd(k == len ? stop : 3'h7, b, 11'h000, 1'b0, 16'h0000);
        c = (col & ~(bl - 1)) | ((col + k - cl) & (bl - 1));
        if (k >= cl) check(dq_oe, 1'b1);
        if (k >= cl) check(dq_out, exp_mem[{b, c}]);
      end
      nop(1'b0);
      check(dq_oe, stop == 3'h5);
      if (stop == 3'h5) check(dq_out, exp_mem[{b, 4'h0}]);
      for (k = 0; k < 10; k = k + 1) nop(1'b0);
    end
  endtask
  initial begin
    #50 reset = 1'b0;
    @(negedge clk_sys);
    check(partial_array_refresh_bank_mask, 4'hF);
    check(drive_ohms, 7'h19);
    for (i = 0; i < 8; i = i + 1) begin
      j = rnd();
      ctl_u.cmd(3'h0, 2'h2, {j[10:7], i[1:0], j[4:3], i[2:0]}, 1'b0, 16'h0000);
      ctl_u.cmd(3'h0, 2'h0, 11'h022, 1'b0, 16'h0000);
      nop(1'b0);
      check(partial_array_refresh_bank_mask, exp_mask(i[2:0]));
      check(partial_array_refresh_row_msb_zero, {i[2:0] == 3'h6, i[2:0] == 3'h5 || i[2:0] == 3'h6});
      check(drive_ohms, exp_ohm(i[1:0]));
    end
    // A load offered while the clock enable is low must leave the store alone
    clk_en = 1'b0;
    ctl_u.cmd(3'h0, 2'h2, 11'h041, 1'b0, 16'h0000);
    nop(1'b0);
    nop(1'b0);
    check(partial_array_refresh_bank_mask, exp_mask(3'h7));
    check(drive_ohms, exp_ohm(2'h3));
    clk_en = 1'b1;
    $display("extended mode test done");
    for (i = 0; i < 4; i = i + 1) begin
      ctl_u.cmd(3'h3, i[1:0], i[10:0], 1'b0, 16'h0000);
      nop(1'b0);
    end
    nop(1'b0);
    check(bank_open, 4'hF);
    for (i = 0; i < 64; i = i + 1) begin
      j = rnd();
      exp_mem[i] = j[15:0];
      ctl_u.cmd(3'h4, i[5:4], {7'h00, i[3:0]}, 1'b0, j[15:0]);
    end
    $display("activate and write test done");
    for (i = 0; i < 8; i = i + 1) begin
      j = rnd();
      ctl_u.cmd(3'h0, 2'h0, {4'h0, (i[2] ? 3'h3 : 3'h2), 2'h0, i[1:0]}, 1'b0, 16'h0000);
      nop(1'b0);
      rd_chk(j[5:4], j[3:0], 2 + i[2], 1 << i[1:0], 1 << i[1:0], 3'h7);
    end
    ctl_u.cmd(3'h0, 2'h0, 11'h037, 1'b0, 16'h0000);
    rd_chk(2'h1, 4'hE, 3, 16, 4, 3'h6);
    ctl_u.cmd(3'h0, 2'h0, 11'h023, 1'b0, 16'h0000);
    rd_chk(2'h2, 4'h5, 2, 8, 3, 3'h2);
    check(bank_open, 4'hB);
    rd_chk(2'h0, 4'h3, 2, 8, 2, 3'h5);
    $display("read burst test done");
    for (i = 0; i < 2; i = i + 1) begin
      j = rnd();
      ctl_u.cmd(3'h5, 2'h0, 11'h000, i == 0, 16'h0000);
      if (i == 0) nop(1'b1);
      ctl_u.cmd(3'h4, 2'h3, 11'h009, 1'b0, j[15:0]);
      check(dq_oe, 1'b0);
      if (i == 0) exp_mem[57] = j[15:0];
      nop(1'b0);
      check(dq_oe, 1'b0);
      flag = invalid_write;
      nop(1'b0);
      check(flag | invalid_write, i[0]);
      rd_chk(2'h3, 4'h9, 2, 8, 8, 3'h7);
    end
    ctl_u.cmd(3'h2, 2'h0, 11'h400, 1'b0, 16'h0000);
    nop(1'b0);
    check(bank_open, 4'h0);
    // Reopen a closed bank on a new row, then let auto-precharge close it
    ctl_u.cmd(3'h3, 2'h1, 11'h005, 1'b0, 16'h0000);
    for (i = 0; i < 3; i = i + 1) nop(1'b0);
    check(bank_open, 4'h2);
    ctl_u.cmd(3'h5, 2'h1, 11'h400, 1'b0, 16'h0000);
    for (i = 0; i < 3; i = i + 1) nop(1'b0);
    check(bank_open, 4'h2);
    for (i = 0; i < 8; i = i + 1) nop(1'b0);
    check(bank_open, 4'h0);
    $display("write cut test done");
    close_out;
  end
  initial begin
    #200000;
    fail_count = fail_count + 1;
    $display("watchdog expired");
    close_out;
  end
endmodule
